// ### common/dscd_pkg.sv
// constants, commands and carriers of the serial command decoder
package dscd_pkg;

   localparam int NUM_CH        = 16;
   localparam int CH_W          = 4;
   localparam int WORD_W        = 16;
   localparam int FRAME_W       = 24;
   localparam int BYTE_W        = 8;

   // frame field positions
   localparam int FRAME_BIT_TOP = 23;
   localparam int CMD_LSB       = 20;
   localparam int SEL_LSB       = 16;
   localparam int LOW_IGN_W     = 4;

   // bus speeds the link accepts
   localparam int SCL_STD_KHZ   = 100;
   localparam int SCL_FAST_KHZ  = 400;

   // seven-bit slave address, upper five bits fixed
   localparam logic [4:0] SLV_ADDR_HI = 5'h03;
   localparam logic [3:0] BIT_ACK     = 4'h8;
   localparam logic [3:0] BIT_LAST    = 4'h7;
   localparam logic [1:0] BYTE_LAST   = 2'h2;

   localparam logic [WORD_W-1:0] CODE_RST = 16'h0000;
   localparam logic [WORD_W-1:0] MASK_RST = 16'h0000;
   localparam logic [WORD_W-1:0] REF_RST  = 16'h0000;

   typedef enum logic [3:0] {
      CMD_NOP        = 4'b0000,
      CMD_WR_IN      = 4'b0001,
      CMD_UPD_MASK   = 4'b0010,
      CMD_WR_UPD     = 4'b0011,
      CMD_POWER      = 4'b0100,
      CMD_LOAD_MASK  = 4'b0101,
      CMD_SOFT_RST   = 4'b0110,
      CMD_REF_SETUP  = 4'b0111,
      CMD_READBACK   = 4'b1001,
      CMD_WR_IN_ALL  = 4'b1010,
      CMD_WR_UPD_ALL = 4'b1011
   } dscd_cmd_t;

   typedef enum logic [1:0] {
      LNK_ADDR  = 2'b00,
      LNK_WRITE = 2'b01,
      LNK_READ  = 2'b10,
      LNK_IDLE  = 2'b11
   } dscd_link_t;

   typedef struct packed {
      logic [3:0]        cmd;
      logic [CH_W-1:0]   sel;
      logic [WORD_W-1:0] data;
   } dscd_frame_t;

   typedef struct packed {
      logic              valid;
      logic [CH_W-1:0]   sel;
      logic [WORD_W-1:0] data;
   } dscd_pwr_req_t;

endpackage

// ### dv/dscd_asserts.sv
// assertion checker of the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module dscd_asserts (
   input wire logic                    clock,      // system clock
   input wire logic                    sys_rst,    // async reset
   input wire logic                    scl_clk,    // bus clock
   input wire logic                    sda_in,     // bus level
   input wire logic                    sda_out,    // drive level
   input wire logic                    sda_oe,     // pull low
   input wire logic [1:0]              addr_pin,   // straps
   input wire logic                    load_output_strobe_n, // load
   input wire logic                    res12_mode, // twelve bit
   input wire logic [15:0][15:0]       dac_code,   // dac registers
   input wire dscd_pkg::dscd_pwr_req_t power_req,  // power request
   input wire logic [15:0]             load_mask,  // strobe mask
   input wire logic [15:0]             ref_setup,  // reference word
   input wire logic                    readback_en, // readback on
   input wire logic [3:0]              readback_ch  // readback channel
);
   logic [15:0] nib_nz;
   always_comb
   begin
      for (int i = 0; i < 16; i++)
         nib_nz[i] = |dac_code[i][3:0];
   end
   // read data also moves sda_oe, so ack timing is judged only while readback_en is low
   sequence s_ack_end;
      $fell(sda_oe) && !readback_en;
   endsequence
   sequence s_quiet;
      !sda_oe [*7];
   endsequence
   rst_vals_a: assert property (@(posedge clock)
      disable iff (sys_rst) $fell(sys_rst) |-> dac_code == '0
      && load_mask == 16'h0000 && ref_setup == 16'h0000 && !readback_en)
      else $error("outputs not cleared by reset");
   sda_low_a: assert property (@(posedge clock)
      disable iff (sys_rst) !sda_out)
      else $error("data line driven high");
   ack_len_a: assert property (@(negedge scl_clk)
      disable iff (sys_rst) $rose(sda_oe) && !readback_en |=> !sda_oe)
      else $error("ack longer than one bit");
   ack_gap_a: assert property (@(negedge scl_clk)
      disable iff (sys_rst) s_ack_end |=> s_quiet)
      else $error("ack before eight data bits");
   pwr_pulse_a: assert property (@(posedge clock)
      disable iff (sys_rst) power_req.valid |=> !power_req.valid)
      else $error("power request not a pulse");
   pwr_sel_a: assert property (@(posedge clock)
      disable iff (sys_rst) $changed(power_req.sel)
      || $changed(power_req.data) |-> power_req.valid)
      else $error("power fields moved without request");
   rb_set_a: assert property (@(posedge clock)
      disable iff (sys_rst)
      $changed(readback_ch) && readback_ch != 4'h0 |-> readback_en)
      else $error("readback channel set without enable");
   res12_a: assert property (@(posedge clock)
      disable iff (sys_rst)
      res12_mode && $changed(dac_code) |-> nib_nz == 16'h0000)
      else $error("low data bits kept in twelve bit mode");
endmodule
bind dscd_command_decoder dscd_asserts u_dscd_asserts (
   .clock(clock), .sys_rst(sys_rst), .scl_clk(scl_clk),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .addr_pin(addr_pin), .load_output_strobe_n(load_output_strobe_n),
   .res12_mode(res12_mode), .dac_code(dac_code), .power_req(power_req),
   .load_mask(load_mask), .ref_setup(ref_setup),
   .readback_en(readback_en), .readback_ch(readback_ch)
);
`default_nettype wire

// ### dv/dscd_bus_master.sv
// behavioural two-wire bus master facing the decoder
`timescale 1ns/1ps
`default_nettype none
module dscd_bus_master (
   output logic     scl_clk,  // bus clock, idles high
   output logic     sda_low,  // pulls data low
   input wire logic sda_line  // resolved data level
);
   localparam time Q = 20ns;
   initial
   begin
      scl_clk = 1'b1;
      sda_low = 1'b0;
   end
   task automatic bus_start();
      #Q sda_low = 1'b1;
      #Q scl_clk = 1'b0;
      #Q;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_low = !b[i];
         #Q scl_clk = 1'b1;
         #(2*Q) scl_clk = 1'b0;
         #Q;
      end
      sda_low = 1'b0;
      #Q scl_clk = 1'b1;
      #Q ack = !sda_line;
      #Q scl_clk = 1'b0;
      #Q;
   endtask
   // ack_out high acks the byte; the line is left as set until next use
   task automatic read_byte(input logic ack_out, output logic [7:0] b);
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         #Q scl_clk = 1'b1;
         #Q b[i] = sda_line;
         #Q scl_clk = 1'b0;
         #Q;
      end
      sda_low = ack_out;
      #Q scl_clk = 1'b1;
      #(2*Q) scl_clk = 1'b0;
      #Q;
   endtask
   task automatic bus_stop();
      sda_low = 1'b1;
      #Q scl_clk = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench of the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic scl_clk, sda_low, sda_out, sda_oe, readback_en, rb_en_m;
   logic load_output_strobe_n, res12_mode;
   logic [1:0] addr_pin;
   logic [3:0] readback_ch, rb_ch_m;
   logic [15:0][15:0] dac_code;
   logic [15:0] load_mask, ref_setup, mask_m, ref_m;
   logic [15:0] in_m [16];
   logic [15:0] dac_m [16];
   dscd_pkg::dscd_pwr_req_t power_req;
   wire sda_line;
   int n_fail = 0;
   int n_tests = 0;
   always #2 clock = ~clock;
   // pull-up: line is high unless someone pulls it low
   assign sda_line = !(sda_low || sda_oe);
   dscd_command_decoder u_dscd_command_decoder (
      .clock(clock), .sys_rst(sys_rst), .scl_clk(scl_clk),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_pin(addr_pin), .load_output_strobe_n(load_output_strobe_n),
      .res12_mode(res12_mode), .dac_code(dac_code), .power_req(power_req),
      .load_mask(load_mask), .ref_setup(ref_setup),
      .readback_en(readback_en), .readback_ch(readback_ch));
   dscd_bus_master u_dscd_bus_master (
      .scl_clk(scl_clk), .sda_low(sda_low), .sda_line(sda_line));
   task automatic summarize();
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_all();
      for (int i = 0; i < 16; i++)
         cmp(dac_code[i], dac_m[i]);
      cmp(load_mask, mask_m);
      cmp(ref_setup, ref_m);
      cmp({11'h0, readback_en, readback_ch}, {11'h0, rb_en_m, rb_ch_m});
   endtask
   task automatic apply(input logic [3:0] c, input logic [3:0] ch,
                        input logic [15:0] d);
      logic [15:0] w;
      w = res12_mode ? {d[15:4], 4'h0} : d;
      if (c == 4'h5)
         mask_m = d;
      if (c == 4'h7)
         ref_m = d;
      if (c == 4'h9)
         {rb_en_m, rb_ch_m} = {1'b1, ch};
      if (c == 4'h6)
         {mask_m, ref_m, rb_en_m, rb_ch_m} = '0;
      for (int i = 0; i < 16; i++)
      begin
         if (c == 4'h6)
            {in_m[i], dac_m[i]} = '0;
         if ((c == 4'h1 || c == 4'h3) && i == ch || c[3:1] == 3'h5)
            in_m[i] = w;
         if (c == 4'h3 && i == ch || c == 4'hB || c == 4'h2 && d[i])
            dac_m[i] = in_m[i];
         if (!load_output_strobe_n && !mask_m[i])
            dac_m[i] = in_m[i];
      end
   endtask
   task automatic send(input logic [3:0] c, input logic [3:0] ch,
                       input logic [15:0] d, input int nb);
      logic [23:0] f;
      logic ack;
      f = {c, ch, d};
      u_dscd_bus_master.bus_start();
      u_dscd_bus_master.send_byte({5'h03, addr_pin, 1'b0}, ack);
      cmp({15'h0, ack}, 16'h0001);
      for (int k = 0; k < nb; k++)
      begin
         u_dscd_bus_master.send_byte(f[23-8*k -: 8], ack);
         cmp({15'h0, ack}, 16'h0001);
      end
      u_dscd_bus_master.bus_stop();
      repeat (12) @(negedge clock);
      if (nb == 3)
         apply(c, ch, d);
      check_all();
   endtask
   task automatic t_refuse();
      logic       ack;
      logic [7:0] b;
      for (int k = 0; k < 3; k++)
      begin
         b = (k == 0) ? 8'h00 : (k == 1) ? 8'hF0 : {5'h03, ~addr_pin, 1'b0};
         u_dscd_bus_master.bus_start();
         u_dscd_bus_master.send_byte(b, ack);
         cmp({15'h0, ack}, 16'h0000);
         u_dscd_bus_master.bus_stop();
      end
      send(4'h1, 4'h0, 16'h1111, 2);
   endtask
   task automatic t_write();
      send(4'h1, 4'h3, 16'h1234, 3);
      send(4'h2, 4'h0, 16'h0008, 3);
      send(4'h3, 4'hF, 16'hBEEF, 3);
      send(4'hA, 4'h0, 16'h5A5A, 3);
      send(4'h2, 4'h0, 16'h8001, 3);
      send(4'hB, 4'h0, 16'hC3C3, 3);
   endtask
   task automatic t_config();
      logic [3:0] rsv [6] = '{4'h0, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
      send(4'h5, 4'h0, 16'h0020, 3);
      send(4'h7, 4'h0, 16'h0003, 3);
      send(4'h9, 4'h9, 16'h0000, 3);
      send(4'h4, 4'h6, 16'h00A5, 3);
      cmp({12'h0, power_req.sel}, 16'h0006);
      cmp(power_req.data, 16'h00A5);
      foreach (rsv[k])
         send(rsv[k], 4'h1, 16'hFFFF, 3);
   endtask
   task automatic t_strobe();
      @(negedge clock);
      load_output_strobe_n = 1'b0;
      send(4'h1, 4'h4, 16'h4444, 3);
      send(4'h1, 4'h5, 16'h5555, 3);
      load_output_strobe_n = 1'b1;
      send(4'h1, 4'h4, 16'h0404, 3);
   endtask
   task automatic t_read();
      logic       ack;
      logic [7:0] b [4];
      send(4'h1, 4'h0, 16'h0F0F, 3);
      send(4'h9, 4'hF, 16'h0000, 3);
      u_dscd_bus_master.bus_start();
      u_dscd_bus_master.send_byte({5'h03, addr_pin, 1'b1}, ack);
      cmp({15'h0, ack}, 16'h0001);
      for (int k = 0; k < 4; k++)
         u_dscd_bus_master.read_byte(k != 3, b[k]);
      u_dscd_bus_master.bus_stop();
      cmp({b[0], b[1]}, in_m[15]);
      cmp({b[2], b[3]}, in_m[0]);
      rb_ch_m = 4'h0;
      repeat (12) @(negedge clock);
      check_all();
   endtask
   task automatic t_soft();
      send(4'h6, 4'h0, 16'h0000, 3);
      res12_mode = 1'b1;
      send(4'h3, 4'h2, 16'hABCD, 3);
   endtask
   initial
   begin
      addr_pin = 2'h2;
      load_output_strobe_n = 1'b1;
      res12_mode = 1'b0;
      {mask_m, ref_m, rb_en_m, rb_ch_m} = '0;
      in_m = '{default: 16'h0000};
      dac_m = '{default: 16'h0000};
      repeat (12) @(negedge clock);
      sys_rst = 1'b0;
      repeat (8) @(negedge clock);
      check_all();
      t_refuse();
      t_write();
      t_config();
      t_strobe();
      t_read();
      t_soft();
      summarize();
   end
   initial
   begin
      #400us;
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire

// ### verilog/dscd_command_decoder.sv
// two-wire slave front end and frame decoder for sixteen dac channels
// Notes on behaviour
// - slave on a two-wire bus, standard 100 kHz and fast 400 kHz.
// - ten-bit and general call addresses get no acknowledge.
// - frame shifts into a 24-bit register, top bit first.
// - bits 23:20 command, 19:16 channel, 15:0 data word.
// - channel field is a plain binary channel number 0 to 15.
// - in twelve-bit mode the four lowest data bits of codes written to input and dac registers are ignored.
// - all 24 bits are captured before the frame is acted on.
// - commands hit one channel, a masked set, or all channels.
// - command 0001 writes the selected input register only.
// - load strobe low makes unmasked input registers transparent.
// - command 0010 copies input registers to dac registers.
// - for 0010 each set data bit selects its channel.
// - command 0011 writes input and dac register of one channel.
// - command 0100 issues a power up or down request.
// - command 0101 loads the load strobe mask register.
// - command 0110 resets all registers except the power request fields as at power on.
// - command 0111 loads the reference setup register.
// - command 1001 enables readback of the selected channel.
// - command 1010 writes every input register at once.
// - command 1011 writes every input and dac register at once.
// - slave address is 00011 followed by two address pins.
// - readback wraps from channel 15 back to channel 0.
`timescale 1ns/1ps
`default_nettype none

module dscd_command_decoder (
   input  wire logic                  clock,       // system clock
   input  wire logic                  sys_rst,     // async reset
   input  wire logic                  scl_clk,     // bus clock
   input  wire logic                  sda_in,      // bus data level
   output logic                       sda_out,     // always low
   output logic                       sda_oe,      // pull data low
   input  wire logic [1:0]            addr_pin,    // address straps
   input  wire logic                  load_output_strobe_n, // load pin
   input  wire logic                  res12_mode,  // twelve-bit part
   output logic [dscd_pkg::NUM_CH-1:0][dscd_pkg::WORD_W-1:0]
                                      dac_code,    // dac registers
   output dscd_pkg::dscd_pwr_req_t    power_req,   // power request
   output logic [dscd_pkg::WORD_W-1:0] load_mask,  // strobe mask
   output logic [dscd_pkg::WORD_W-1:0] ref_setup,  // reference setup
   output logic                       readback_en, // readback on
   output logic [dscd_pkg::CH_W-1:0]  readback_ch  // readback channel
);

   // ---- system side: pin synchronisers and start/stop detection
   logic scl_s1;
   logic scl_s2;
   logic scl_d;
   logic sda_s1;
   logic sda_s2;
   logic sda_d;
   logic link_hold;
   logic link_clr;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end
      else
      begin
         scl_s1 <= scl_clk;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   // start or stop holds the link logic cleared while scl stays high;
   // the first bit edge comes only after scl has fallen, long after this
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         link_hold <= 1'b0;
      else if (scl_s2 && scl_d && (sda_s2 != sda_d))
         link_hold <= 1'b1;
      else if (!scl_s2)
         link_hold <= 1'b0;
   end

   assign link_clr = sys_rst | link_hold;

   // ---- link side, clocked by the bus clock
   logic [1:0]                    addr_s1;
   logic [1:0]                    addr_s2;
   dscd_pkg::dscd_link_t          lnk_state;
   logic [3:0]                    bit_cnt;
   logic [1:0]                    byte_cnt;
   logic [dscd_pkg::BYTE_W-1:0]   shift;
   logic [dscd_pkg::BYTE_W-1:0]   rx_byte;
   logic                          ack_ok;
   logic                          rd_low;
   logic                          frame_tgl;
   logic                          word_tgl;
   dscd_pkg::dscd_frame_t         frame_q;
   logic [dscd_pkg::WORD_W-1:0]   rd_word;
   logic [dscd_pkg::BYTE_W-1:0]   tx_byte;
   logic                          tx_bit;
   logic                          addr_hit;

   always_ff @(posedge scl_clk or posedge link_clr)
   begin
      if (link_clr)
      begin
         addr_s1 <= 2'h0;
         addr_s2 <= 2'h0;
      end
      else
      begin
         addr_s1 <= addr_pin;
         addr_s2 <= addr_s1;
      end
   end

   assign rx_byte  = {shift[dscd_pkg::BYTE_W-2:0], sda_in};
   // fixed upper bits never match general call or ten-bit headers
   assign addr_hit = (rx_byte[7:3] == dscd_pkg::SLV_ADDR_HI) &&
                     (rx_byte[2:1] == addr_s2);

   // data is sampled on rising scl, so the frame bits stand on the
   // falling edges before them
   always_ff @(posedge scl_clk or posedge link_clr)
   begin
      if (link_clr)
      begin
         lnk_state <= dscd_pkg::LNK_ADDR;
         bit_cnt   <= 4'h0;
         byte_cnt  <= 2'h0;
         shift     <= 8'h00;
         ack_ok    <= 1'b0;
         rd_low    <= 1'b0;
      end
      else if (bit_cnt == dscd_pkg::BIT_ACK)
      begin
         bit_cnt <= 4'h0;
         ack_ok  <= 1'b0;
         // ack_ok still high means this was our own address ack
         if (lnk_state == dscd_pkg::LNK_READ && !ack_ok)
         begin
            if (sda_in)
               lnk_state <= dscd_pkg::LNK_IDLE;
            rd_low <= !rd_low;
         end
      end
      else
      begin
         shift   <= rx_byte;
         bit_cnt <= bit_cnt + 4'h1;
         if (bit_cnt == dscd_pkg::BIT_LAST)
         begin
            case (lnk_state)
               dscd_pkg::LNK_ADDR:
               begin
                  ack_ok <= addr_hit;
                  if (!addr_hit)
                     lnk_state <= dscd_pkg::LNK_IDLE;
                  else if (rx_byte[0])
                     lnk_state <= dscd_pkg::LNK_READ;
                  else
                     lnk_state <= dscd_pkg::LNK_WRITE;
               end
               dscd_pkg::LNK_WRITE:
               begin
                  ack_ok <= 1'b1;
                  if (byte_cnt == dscd_pkg::BYTE_LAST)
                     byte_cnt <= 2'h0;
                  else
                     byte_cnt <= byte_cnt + 2'h1;
               end
               default:
                  ack_ok <= 1'b0;
            endcase
         end
      end
   end

   // frame register and completion toggles live outside the clear so
   // the system side can still read the last frame after a stop
   always_ff @(posedge scl_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         frame_q   <= '0;
         frame_tgl <= 1'b0;
         word_tgl  <= 1'b0;
      end
      else if (!link_hold && bit_cnt == dscd_pkg::BIT_LAST &&
               lnk_state == dscd_pkg::LNK_WRITE)
      begin
         case (byte_cnt)
            2'h0: frame_q[23:16] <= rx_byte;
            2'h1: frame_q[15:8]  <= rx_byte;
            default:
            begin
               frame_q[7:0] <= rx_byte;
               frame_tgl    <= !frame_tgl;
            end
         endcase
      end
      else if (!link_hold && bit_cnt == dscd_pkg::BIT_ACK &&
               lnk_state == dscd_pkg::LNK_READ && !sda_in && rd_low &&
               !ack_ok)
         word_tgl <= !word_tgl;
   end

   // rd_word follows in_all[readback_ch] every clock; readback_ch steps after word_tgl, half a bus period before use
   assign tx_byte = rd_low ? rd_word[7:0] : rd_word[15:8];
   assign tx_bit  = tx_byte[3'(dscd_pkg::BIT_LAST - bit_cnt[2:0])];

   always_ff @(negedge scl_clk or posedge link_clr)
   begin
      if (link_clr)
         sda_oe <= 1'b0;
      else if (bit_cnt == dscd_pkg::BIT_ACK)
         sda_oe <= ack_ok;
      else
         sda_oe <= (lnk_state == dscd_pkg::LNK_READ) && !tx_bit;
   end

   assign sda_out = 1'b0;

   // ---- system side: toggle crossings back from the link, strobe and mode pin synchronisers
   logic       ftg_s1;
   logic       ftg_s2;
   logic       ftg_d;
   logic       wtg_s1;
   logic       wtg_s2;
   logic       wtg_d;
   logic       load_output_strobe_s1;
   logic       load_output_strobe_s2;
   logic       res_s1;
   logic       res_s2;
   logic       frame_go;
   logic       word_go;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ftg_s1  <= 1'b0;
         ftg_s2  <= 1'b0;
         ftg_d   <= 1'b0;
         wtg_s1  <= 1'b0;
         wtg_s2  <= 1'b0;
         wtg_d   <= 1'b0;
         load_output_strobe_s1 <= 1'b1;
         load_output_strobe_s2 <= 1'b1;
         res_s1  <= 1'b0;
         res_s2  <= 1'b0;
      end
      else
      begin
         ftg_s1  <= frame_tgl;
         ftg_s2  <= ftg_s1;
         ftg_d   <= ftg_s2;
         wtg_s1  <= word_tgl;
         wtg_s2  <= wtg_s1;
         wtg_d   <= wtg_s2;
         load_output_strobe_s1 <= load_output_strobe_n;
         load_output_strobe_s2 <= load_output_strobe_s1;
         res_s1  <= res12_mode;
         res_s2  <= res_s1;
      end
   end

   assign frame_go = ftg_s2 ^ ftg_d;
   assign word_go  = wtg_s2 ^ wtg_d;

   // ---- frame decode
   dscd_pkg::dscd_cmd_t           cmd;
   logic [dscd_pkg::CH_W-1:0]     sel;
   logic [dscd_pkg::WORD_W-1:0]   data_raw;
   logic [dscd_pkg::WORD_W-1:0]   data_code;
   logic                          soft_rst;

   assign cmd       = dscd_pkg::dscd_cmd_t'(frame_q.cmd);
   assign sel       = frame_q.sel;
   assign data_raw  = frame_q.data;
   assign data_code = res_s2 ?
      {data_raw[dscd_pkg::WORD_W-1:dscd_pkg::LOW_IGN_W],
       dscd_pkg::LOW_IGN_W'(0)} : data_raw;
   assign soft_rst  = frame_go && cmd == dscd_pkg::CMD_SOFT_RST;

   // ---- per channel input and dac registers
   logic [dscd_pkg::NUM_CH-1:0][dscd_pkg::WORD_W-1:0] in_all;

   genvar ch;
   generate
      for (ch = 0; ch < dscd_pkg::NUM_CH; ch++)
      begin : g_ch
         logic [dscd_pkg::WORD_W-1:0] in_q;
         logic [dscd_pkg::WORD_W-1:0] dac_q;
         logic                        hit;

         assign hit = (sel == dscd_pkg::CH_W'(ch));

         always_ff @(posedge clock or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               in_q  <= dscd_pkg::CODE_RST;
               dac_q <= dscd_pkg::CODE_RST;
            end
            else if (frame_go)
            begin
               case (cmd)
                  dscd_pkg::CMD_WR_IN:
                     if (hit)
                        in_q <= data_code;
                  dscd_pkg::CMD_UPD_MASK:
                     if (data_raw[ch])
                        dac_q <= in_q;
                  dscd_pkg::CMD_WR_UPD:
                     if (hit)
                     begin
                        in_q  <= data_code;
                        dac_q <= data_code;
                     end
                  dscd_pkg::CMD_WR_IN_ALL:
                     in_q <= data_code;
                  dscd_pkg::CMD_WR_UPD_ALL:
                  begin
                     in_q  <= data_code;
                     dac_q <= data_code;
                  end
                  dscd_pkg::CMD_SOFT_RST:
                  begin
                     in_q  <= dscd_pkg::CODE_RST;
                     dac_q <= dscd_pkg::CODE_RST;
                  end
                  default:
                     in_q <= in_q;
               endcase
            end
            // transparency lags a fresh write by one clock
            else if (!load_output_strobe_s2 && !load_mask[ch])
               dac_q <= in_q;
         end

         assign in_all[ch]   = in_q;
         assign dac_code[ch] = dac_q;
      end
   endgenerate

   // ---- configuration registers
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         load_mask <= dscd_pkg::MASK_RST;
      else if (soft_rst)
         load_mask <= dscd_pkg::MASK_RST;
      else if (frame_go && cmd == dscd_pkg::CMD_LOAD_MASK)
         load_mask <= data_raw;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         ref_setup <= dscd_pkg::REF_RST;
      else if (soft_rst)
         ref_setup <= dscd_pkg::REF_RST;
      else if (frame_go && cmd == dscd_pkg::CMD_REF_SETUP)
         ref_setup <= data_raw;
   end

   // power request is a one-cycle pulse with the frame contents
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         power_req <= '0;
      else
      begin
         power_req.valid <= frame_go && cmd == dscd_pkg::CMD_POWER;
         if (frame_go && cmd == dscd_pkg::CMD_POWER)
         begin
            power_req.sel  <= sel;
            power_req.data <= data_raw;
         end
      end
   end

   // ---- readback pointer and word offered to the link
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         readback_en <= 1'b0;
         readback_ch <= '0;
      end
      else if (soft_rst)
      begin
         readback_en <= 1'b0;
         readback_ch <= '0;
      end
      else if (frame_go && cmd == dscd_pkg::CMD_READBACK)
      begin
         readback_en <= 1'b1;
         readback_ch <= sel;
      end
      else if (word_go)
         readback_ch <= readback_ch + dscd_pkg::CH_W'(1);
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         rd_word <= dscd_pkg::CODE_RST;
      else
         rd_word <= in_all[readback_ch];
   end

endmodule

`default_nettype wire
